//--- logic/fdtm_fifo.sv
// bit fifo between the transmit uart and the modulator
`timescale 1ns/1ps
`default_nettype none
module fdtm_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 4
) (
   input  wire logic             i_ref_clk,   // clock
   input  wire logic             i_rst_n,     // sync reset
   input  wire logic             i_in_valid,  // source has data
   input  wire logic [WIDTH-1:0] i_in_data,   // source data
   output logic                  o_in_ready,  // room for a word
   output logic                  o_out_valid, // word available
   output logic      [WIDTH-1:0] o_out_data,  // head word
   input  wire logic             i_out_ready  // sink takes head
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
      $error("fdtm_fifo: DEPTH must be a power of two >= 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
      logic                        full;
   } fdtm_fifo_t;

   fdtm_fifo_t s, next_s;
   logic       push, pop;

   always_comb begin
      next_s = s;
      push   = i_in_valid && !s.full;
      pop    = i_out_ready && (s.cnt != '0);
      if (push) begin
         next_s.mem[s.wr] = i_in_data;
         next_s.wr        = s.wr + 1'b1;
      end
      if (pop) begin
         next_s.rd = s.rd + 1'b1;
      end
      next_s.cnt  = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
      next_s.full = (next_s.cnt == (AW+1)'(DEPTH));
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // full is a flop so ready never waits on the sink
   assign o_in_ready  = !s.full;
   assign o_out_valid = (s.cnt != '0);
   assign o_out_data  = s.mem[s.rd];
endmodule // fdtm_fifo
`default_nettype wire

//--- logic/fdtm_modulator.sv
// fsk / dtmf tone modulator with avalon-mm register slave
//
// Contract
// - With tone mode off, FSK is produced from setup bit 7, mode bits 0/1 and the current bit.
// - With mode bit 1 low in FSK, the output sits at mid level whatever bit 0.
// - V.23 plan: 75 bps 450/390 Hz or 1200 bps 2100/1300 Hz (space/mark).
// - Bell plan: 150 bps 487/387 Hz or 1200 bps 2200/1200 Hz (space/mark).
// - With tone mode on, DTMF pairs or single tones replace FSK.
// - In tone mode, gate bit 6 passes the tone when 1 and blocks it when 0.
// - Tone bit 4 picks single tone; codes below 8 give upper, others lower.
// - The 4-bit code selects the DTMF row and column frequency pair.
// - Mode bit 2 selects the high transmit filter level.
// - Setup bit 6 enables the inverting balanced output only.
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fdtm_modulator
   import fdtm_pkg::*;
#(
   parameter int P_BIT_CYC_V23  = BIT_CYC_V23,  // 75 bps bit period
   parameter int P_BIT_CYC_BELL = BIT_CYC_BELL, // 150 bps bit period
   parameter int P_BIT_CYC_HI   = BIT_CYC_HI,   // 1200 bps bit period
   parameter int P_FIFO_DEPTH   = 4             // transmit bit buffer
) (
   input  wire logic        i_ref_clk,          // 50 MHz clock
   input  wire logic        i_rst_n,            // sync reset
   input  wire logic [4:0]  i_avs_address,      // byte address
   input  wire logic        i_avs_read,         // read request
   input  wire logic        i_avs_write,        // write request
   input  wire logic [31:0] i_avs_writedata,    // write data
   input  wire logic [3:0]  i_avs_byteenable,   // byte lanes
   output logic      [31:0] o_avs_readdata,     // read data
   output logic             o_avs_waitrequest,  // stall
   input  wire logic        i_tx_bit_valid,     // uart bit offered
   input  wire logic        i_tx_bit,           // uart bit, 1 = mark
   output logic             o_tx_bit_ready,     // bit accepted
   output logic      [7:0]  o_tx_sample,        // modulator sample
   output logic             o_level_high,       // filter +3 dB
   output logic             o_balanced_inverting_output_en // inverting out
);
   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (P_BIT_CYC_V23 < 2 || P_BIT_CYC_BELL < 2 || P_BIT_CYC_HI < 2 ||
       P_BIT_CYC_V23 >= (1 << 20) || P_BIT_CYC_BELL >= (1 << 20) ||
       P_BIT_CYC_HI >= (1 << 20)) begin : g_chk
      $error("fdtm_modulator: bit period out of range");
   end

   typedef struct packed {
      logic [7:0]      setup;
      logic [7:0]      tones;
      logic [7:0]      mode;
      logic [7:0]      code;
      logic            wait_st;
      logic [31:0]     rdata;
      logic [19:0]     bit_cnt;
      logic            cur_bit;
      logic [PH_W-1:0] ph_a;
      logic [PH_W-1:0] ph_b;
      logic [7:0]      sample;
      logic            level_hi;
      logic            inv_en;
   } fdtm_state_t;

   fdtm_state_t s, next_s;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   function automatic logic [7:0] tri8(input logic [PH_W-1:0] ph);
      return ph[PH_W-1] ? ~ph[PH_W-2 -: 8] : ph[PH_W-2 -: 8];
   endfunction

   function automatic logic [PH_W-1:0] row_inc(input logic [3:0] c);
      unique case (c)
         4'h1, 4'h2, 4'h3, 4'hD: return INC_697;
         4'h4, 4'h5, 4'h6, 4'hE: return INC_770;
         4'h7, 4'h8, 4'h9, 4'hF: return INC_852;
         default:                return INC_941;
      endcase
   endfunction

   function automatic logic [PH_W-1:0] col_inc(input logic [3:0] c);
      unique case (c)
         4'h1, 4'h4, 4'h7, 4'hB: return INC_1209;
         4'h2, 4'h5, 4'h8, 4'hA: return INC_1336;
         4'h3, 4'h6, 4'h9, 4'hC: return INC_1477;
         default:                return INC_1633;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // transmit bit buffer
   // ----------------------------------------------------------------
   logic fifo_valid;
   logic fifo_bit;
   logic pop;

   fdtm_fifo #(
      .WIDTH (1),
      .DEPTH (P_FIFO_DEPTH)
   ) u_fifo (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (i_tx_bit_valid),
      .i_in_data   (i_tx_bit),
      .o_in_ready  (o_tx_bit_ready),
      .o_out_valid (fifo_valid),
      .o_out_data  (fifo_bit),
      .i_out_ready (pop)
   );

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   logic            req;
   logic            tone_mode;
   logic            fsk_en;
   logic            bell;
   logic            fast;
   logic            tick;
   logic [19:0]     bit_len;
   logic [PH_W-1:0] inc_a;
   logic [PH_W-1:0] inc_b;
   logic [8:0]      pair_sum;
   logic [7:0]      rd_val;

   always_comb begin
      next_s    = s;
      req       = i_avs_read || i_avs_write;
      tone_mode = s.tones[TONE_MODE_BIT];
      bell      = s.setup[SETUP_STD_BIT];
      fast      = s.mode[MM_RATE_BIT];
      fsk_en    = !tone_mode && s.mode[MM_EN_BIT];

      // bus slave: wait one cycle, answer with the stall dropped, then raise it again
      next_s.wait_st = !(req && s.wait_st);
      unique case (i_avs_address)
         ADDR_SETUP:  rd_val = s.setup;
         ADDR_TONES:  rd_val = s.tones;
         ADDR_MODE:   rd_val = s.mode;
         ADDR_CODE:   rd_val = s.code;
         ADDR_STATUS: rd_val = {4'h0, tone_mode, fsk_en, fifo_valid, s.cur_bit};
         default:     rd_val = 8'h00;
      endcase
      if (i_avs_read && s.wait_st) begin
         next_s.rdata = {24'h000000, rd_val};
      end
      if (i_avs_write && !s.wait_st && i_avs_byteenable[0]) begin
         unique case (i_avs_address)
            ADDR_SETUP: next_s.setup = i_avs_writedata[7:0];
            ADDR_TONES: next_s.tones = i_avs_writedata[7:0];
            ADDR_MODE:  next_s.mode  = i_avs_writedata[7:0];
            ADDR_CODE:  next_s.code  = i_avs_writedata[7:0];
            default:    ;
         endcase
      end

      // bit timer runs only while fsk transmits
      if (fast) begin
         bit_len = 20'(P_BIT_CYC_HI);
      end else if (bell) begin
         bit_len = 20'(P_BIT_CYC_BELL);
      end else begin
         bit_len = 20'(P_BIT_CYC_V23);
      end
      tick = fsk_en && (s.bit_cnt >= bit_len - 20'h00001);
      pop = tick && fifo_valid;
      if (!fsk_en || tick) begin
         next_s.bit_cnt = 20'h00000;
      end else begin
         next_s.bit_cnt = s.bit_cnt + 20'h00001;
      end
      // empty buffer idles on mark rather than repeating a bit
      if (!fsk_en) begin
         next_s.cur_bit = 1'b1;
      end else if (tick) begin
         next_s.cur_bit = fifo_valid ? fifo_bit : 1'b1;
      end

      if (!bell) begin
         if (fast) begin
            inc_a = s.cur_bit ? INC_1300 : INC_2100;
         end else begin
            inc_a = s.cur_bit ? INC_390 : INC_450;
         end
      end else if (fast) begin
         inc_a = s.cur_bit ? INC_1200 : INC_2200;
      end else begin
         inc_a = s.cur_bit ? INC_387 : INC_487;
      end
      inc_b = col_inc(s.code[3:0]);
      if (tone_mode) begin
         if (s.tones[TONE_SINGLE_BIT] && !s.code[3]) begin
            inc_a = col_inc(s.code[3:0]);
         end else begin
            inc_a = row_inc(s.code[3:0]);
         end
      end

      next_s.ph_a = s.ph_a + inc_a;
      next_s.ph_b = s.ph_b + inc_b;

      pair_sum = {1'b0, tri8(s.ph_a)} + {1'b0, tri8(s.ph_b)};
      if (!tone_mode) begin
         // disabled modulator rests at mid level
         next_s.sample = s.mode[MM_EN_BIT] ? tri8(s.ph_a) : MID;
      end else if (!s.tones[TONE_GATE_BIT]) begin
         next_s.sample = MID;
      end else if (s.tones[TONE_SINGLE_BIT]) begin
         next_s.sample = tri8(s.ph_a);
      end else begin
         next_s.sample = pair_sum[8:1];
      end

      next_s.level_hi = s.mode[MM_LEVEL_BIT];
      next_s.inv_en   = s.setup[SETUP_INV_BIT];
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         s         <= '0;
         s.wait_st <= 1'b1;
         s.cur_bit <= 1'b1;
         s.sample  <= MID;
         s.setup   <= REG_RST;
         s.tones   <= REG_RST;
         s.mode    <= REG_RST;
         s.code    <= REG_RST;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_avs_readdata                 = s.rdata;
   assign o_avs_waitrequest              = s.wait_st;
   assign o_tx_sample                    = s.sample;
   assign o_level_high                   = s.level_hi;
   assign o_balanced_inverting_output_en = s.inv_en;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   logic [PH_W-1:0] prev_a, prev_b, step_a, step_b;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         prev_a <= '0;
         prev_b <= '0;
      end else begin
         prev_a <= s.ph_a;
         prev_b <= s.ph_b;
      end
   end
   assign step_a = s.ph_a - prev_a;
   assign step_b = s.ph_b - prev_b;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   fsk_bit_take_a: assert property (pop |=> s.cur_bit == $past(fifo_bit))
      else $error("fsk bit not taken from buffer");
   fsk_disabled_a: assert property (
      (!tone_mode && !s.mode[MM_EN_BIT]) |=> o_tx_sample == MID)
      else $error("disabled modulator not at mid level");
   v23_slow_space_a: assert property (
      (fsk_en && !bell && !fast && !s.cur_bit) |=> step_a == INC_450)
      else $error("v23 75 bps space frequency wrong");
   bell_fast_mark_a: assert property (
      (fsk_en && bell && fast && s.cur_bit) |=> step_a == INC_1200)
      else $error("bell 1200 bps mark frequency wrong");
   v23_slow_mark_a: assert property (
      (fsk_en && !bell && !fast && s.cur_bit) |=> step_a == INC_390)
      else $error("v23 75 bps mark frequency wrong");
   v23_fast_space_a: assert property (
      (fsk_en && !bell && fast && !s.cur_bit) |=> step_a == INC_2100)
      else $error("v23 1200 bps space frequency wrong");
   v23_fast_mark_a: assert property (
      (fsk_en && !bell && fast && s.cur_bit) |=> step_a == INC_1300)
      else $error("v23 1200 bps mark frequency wrong");
   bell_slow_space_a: assert property (
      (fsk_en && bell && !fast && !s.cur_bit) |=> step_a == INC_487)
      else $error("bell 150 bps space frequency wrong");
   bell_slow_mark_a: assert property (
      (fsk_en && bell && !fast && s.cur_bit) |=> step_a == INC_387)
      else $error("bell 150 bps mark frequency wrong");
   bell_fast_space_a: assert property (
      (fsk_en && bell && fast && !s.cur_bit) |=> step_a == INC_2200)
      else $error("bell 1200 bps space frequency wrong");
   tone_no_bits_a: assert property (tone_mode |-> !pop)
      else $error("tone mode consumed fsk bits");
   tone_gate_a: assert property (
      (tone_mode && !s.tones[TONE_GATE_BIT]) |=> o_tx_sample == MID)
      else $error("gated tone reached output");
   single_lower_a: assert property (
      (tone_mode && s.tones[TONE_SINGLE_BIT] && s.code[3:0] inside {4'h8, 4'h9})
      |=> step_a == INC_852)
      else $error("single tone lower frequency wrong");
   single_upper_a: assert property (
      (tone_mode && s.tones[TONE_SINGLE_BIT] && s.code[3:0] == 4'h7)
      |=> step_a == INC_1209)
      else $error("single tone upper frequency wrong");
   dtmf_pair_a: assert property (
      (tone_mode && !s.tones[TONE_SINGLE_BIT] && s.code[3:0] == 4'h0)
      |=> (step_a == INC_941 && step_b == INC_1633))
      else $error("dtmf pair for code 0 wrong");
   dual_row_col_a: assert property (
      (tone_mode && !s.tones[TONE_SINGLE_BIT] && s.code[3:0] == 4'h5)
      |=> (step_a == INC_770 && step_b == INC_1336))
      else $error("dtmf pair for code 5 wrong");
   level_follow_a: assert property (
      $changed(s.mode[MM_LEVEL_BIT]) |=> o_level_high == $past(s.mode[MM_LEVEL_BIT]))
      else $error("filter level did not follow");
   inv_enable_a: assert property (
      $rose(s.setup[SETUP_INV_BIT]) |-> !o_balanced_inverting_output_en ##1
      o_balanced_inverting_output_en)
      else $error("inverting output enable late");
   // bit, and so frequency, only moves at a boundary
   phase_cont_a: assert property ((fsk_en && !tick) |=> $stable(s.cur_bit))
      else $error("frequency changed between bit boundaries");
   bus_one_wait_a: assert property (
      (req && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("bus access not answered after one wait cycle");

   // ----------------------------------------------------------------
   // cover properties
   // ----------------------------------------------------------------
   cov_bit_change_c: cover property (fsk_en && tick ##1 $changed(s.cur_bit));
   cov_dual_tone_c:  cover property (tone_mode && !s.tones[TONE_SINGLE_BIT]
                                     && s.tones[TONE_GATE_BIT]);
   cov_fifo_full_c:  cover property (!o_tx_bit_ready && i_tx_bit_valid);
   cov_bus_write_c:  cover property (i_avs_write && !o_avs_waitrequest);
   cov_gate_off_c:   cover property (tone_mode && !s.tones[TONE_GATE_BIT]);
endmodule // fdtm_modulator
`default_nettype wire

//--- logic/fdtm_pkg.sv
// package: constants for the fsk/dtmf tone modulator
package fdtm_pkg;
   // ----------------------------------------------------------------
   // clock and phase accumulator
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int          PH_W   = 24;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_SETUP  = 5'h00;
   localparam logic [4:0] ADDR_TONES  = 5'h04;
   localparam logic [4:0] ADDR_MODE   = 5'h08;
   localparam logic [4:0] ADDR_CODE   = 5'h0C;
   localparam logic [4:0] ADDR_STATUS = 5'h10;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int SETUP_STD_BIT   = 7;
   localparam int SETUP_INV_BIT   = 6;
   localparam int TONE_MODE_BIT   = 7;
   localparam int TONE_GATE_BIT   = 6;
   localparam int TONE_SINGLE_BIT = 4;
   localparam int MM_RATE_BIT     = 0;
   localparam int MM_EN_BIT       = 1;
   localparam int MM_LEVEL_BIT    = 2;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] MID     = 8'h80;

   // ----------------------------------------------------------------
   // bit rates and bit periods in clock cycles
   // ----------------------------------------------------------------
   localparam int BAUD_V23_LO  = 75;
   localparam int BAUD_BELL_LO = 150;
   localparam int BAUD_HI      = 1200;
   localparam int BIT_CYC_V23  = CLK_HZ / BAUD_V23_LO;
   localparam int BIT_CYC_BELL = CLK_HZ / BAUD_BELL_LO;
   localparam int BIT_CYC_HI   = CLK_HZ / BAUD_HI;

   function automatic logic [PH_W-1:0] phase_inc(input int unsigned hz);
      longint t;
      t = ((longint'(hz) <<< PH_W) + longint'(CLK_HZ / 2)) / longint'(CLK_HZ);
      return t[PH_W-1:0];
   endfunction

   // ----------------------------------------------------------------
   // phase increments per tone
   // ----------------------------------------------------------------
   localparam logic [PH_W-1:0] INC_450  = phase_inc(450);
   localparam logic [PH_W-1:0] INC_390  = phase_inc(390);
   localparam logic [PH_W-1:0] INC_2100 = phase_inc(2100);
   localparam logic [PH_W-1:0] INC_1300 = phase_inc(1300);
   localparam logic [PH_W-1:0] INC_487  = phase_inc(487);
   localparam logic [PH_W-1:0] INC_387  = phase_inc(387);
   localparam logic [PH_W-1:0] INC_2200 = phase_inc(2200);
   localparam logic [PH_W-1:0] INC_1200 = phase_inc(1200);
   localparam logic [PH_W-1:0] INC_697  = phase_inc(697);
   localparam logic [PH_W-1:0] INC_770  = phase_inc(770);
   localparam logic [PH_W-1:0] INC_852  = phase_inc(852);
   localparam logic [PH_W-1:0] INC_941  = phase_inc(941);
   localparam logic [PH_W-1:0] INC_1209 = phase_inc(1209);
   localparam logic [PH_W-1:0] INC_1336 = phase_inc(1336);
   localparam logic [PH_W-1:0] INC_1477 = phase_inc(1477);
   localparam logic [PH_W-1:0] INC_1633 = phase_inc(1633);
endpackage

//--- testbench/fdtm_uart_model.sv
// uart bit source model feeding the modulator's bit buffer
`timescale 1ns/1ps
`default_nettype none
module fdtm_uart_model (
   input  wire logic i_ref_clk, // clock
   input  wire logic i_ready,   // buffer has room
   output logic      o_valid = 1'b0, // bit offered
   output logic      o_bit   = 1'b1  // bit value, 1 = mark
);
   logic q[$];

   // offer oldest bit, hold it until the buffer takes it
   always @(posedge i_ref_clk) begin
      if (o_valid && i_ready && q.size() != 0) begin
         void'(q.pop_front());
      end
      o_valid <= (q.size() != 0);
      // idle line toggles so a stale bit never passes for data
      o_bit   <= (q.size() != 0) ? q[0] : ~o_bit;
   end
endmodule // fdtm_uart_model
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the fsk/dtmf tone modulator
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import fdtm_pkg::*;
   // ----------
   // signals
   // ----------
   localparam int P_BIT = 7000;
   logic        ref_clk      = 1'b0;
   logic        rst_n        = 1'b0;
   logic [4:0]  addr         = 5'h00;
   logic        rd           = 1'b0;
   logic        wr           = 1'b0;
   logic [31:0] wdata        = 32'h0;
   logic [3:0]  be           = 4'h0;
   logic [31:0] rdata;
   logic        waitreq;
   logic        bit_valid;
   logic        tx_bit;
   logic        bit_ready;
   logic [7:0]  sample;
   logic        level_high;
   logic        inv_en;
   logic [31:0] r;
   int          bad_count    = 0;
   int          total_checks = 0;

   always #10 ref_clk = ~ref_clk;

   fdtm_modulator #(
      .P_BIT_CYC_V23  (P_BIT),
      .P_BIT_CYC_BELL (P_BIT),
      .P_BIT_CYC_HI   (P_BIT),
      .P_FIFO_DEPTH   (4)
   ) u_dut (
      .i_ref_clk                      (ref_clk),
      .i_rst_n                        (rst_n),
      .i_avs_address                  (addr),
      .i_avs_read                     (rd),
      .i_avs_write                    (wr),
      .i_avs_writedata                (wdata),
      .i_avs_byteenable               (be),
      .o_avs_readdata                 (rdata),
      .o_avs_waitrequest              (waitreq),
      .i_tx_bit_valid                 (bit_valid),
      .i_tx_bit                       (tx_bit),
      .o_tx_bit_ready                 (bit_ready),
      .o_tx_sample                    (sample),
      .o_level_high                   (level_high),
      .o_balanced_inverting_output_en (inv_en)
   );

   fdtm_uart_model u_uart (
      .i_ref_clk (ref_clk),
      .i_ready   (bit_ready),
      .o_valid   (bit_valid),
      .o_bit     (tx_bit)
   );

   // ----------
   // shared tasks
   // ----------
   task automatic final_report();
      if (bad_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   // tone rate judged by total swing; assumes a full-scale triangle
   task automatic near(input string name, input int f, input int w, input int tv);
      int e;
      e = int'(longint'(f) * w * 512 / CLK_HZ);
      total_checks++;
      if (tv < e - 3 || tv > e + 3) begin
         bad_count++;
         $display("Error %s expected %0d seen %0d", name, e, tv);
      end
   endtask

   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                      input logic [3:0] b, output logic [31:0] q);
      @(posedge ref_clk);
      addr  <= a;
      wr    <= w;
      rd    <= ~w;
      wdata <= {24'h000000, d};
      be    <= b;
      @(posedge ref_clk);
      // no wait-state count assumed; the watchdog ends a hang
      while (waitreq !== 1'b0) begin
         @(posedge ref_clk);
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic wreg(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1, r);
   endtask

   task automatic rreg(input logic [4:0] a);
      bus(1'b0, a, 8'h00, 4'h1, r);
   endtask

   task automatic tvar(input int w, output int tv);
      logic [7:0] p;
      tv = 0;
      @(posedge ref_clk);
      p = sample;
      repeat (w) begin
         @(posedge ref_clk);
         tv += (sample > p) ? int'(sample - p) : int'(p - sample);
         p = sample;
      end
   endtask

   task automatic hold_mid(input string name, input int n);
      // the first edge after a write still shows the old sample
      @(posedge ref_clk);
      repeat (n) begin
         @(posedge ref_clk);
         check(name, {24'h000000, MID}, {24'h000000, sample});
      end
   endtask

   // pair swing lies between half the difference and the sum of the slopes
   task automatic dual(input logic [7:0] c, input int fr, input int fc);
      int tv;
      int lo;
      int hi;
      wreg(ADDR_CODE, c);
      tvar(3000, tv);
      lo = int'(longint'(fc - fr) * 3000 * 256 / CLK_HZ) - 6;
      hi = int'(longint'(fc + fr) * 3000 * 512 / CLK_HZ) + 3;
      check("dual swing", 32'h1, {31'h0, tv >= lo && tv <= hi});
   endtask

   // ----------
   // scenarios
   // ----------
   task automatic t_reset();
      logic [4:0] regs [5] = '{ADDR_SETUP, ADDR_TONES, ADDR_MODE, ADDR_CODE, ADDR_STATUS};
      check("waitrequest", 32'h1, {31'h0, waitreq});
      check("sample", {24'h000000, MID}, {24'h000000, sample});
      check("level", 32'h0, {31'h0, level_high});
      check("inv_en", 32'h0, {31'h0, inv_en});
      check("bit_ready", 32'h1, {31'h0, bit_ready});
      foreach (regs[i]) begin
         rreg(regs[i]);
         // idle status shows mark as the current bit
         check("reg reset", (regs[i] == ADDR_STATUS) ? 32'h1 : 32'h0, r);
      end
   endtask

   task automatic t_regs();
      wreg(ADDR_SETUP, 8'h40);
      wreg(ADDR_MODE, 8'h04);
      repeat (2) @(posedge ref_clk);
      check("inv_en", 32'h1, {31'h0, inv_en});
      check("level", 32'h1, {31'h0, level_high});
      bus(1'b1, ADDR_SETUP, 8'h00, 4'h0, r);
      wreg(5'h02, 8'h00);
      rreg(ADDR_SETUP);
      check("setup", 32'h40, r);
      rreg(5'h14);
      check("unmapped", 32'h0, r);
   endtask

   task automatic t_disabled();
      wreg(ADDR_MODE, 8'h01);
      repeat (2) @(posedge ref_clk);
      check("level", 32'h0, {31'h0, level_high});
      hold_mid("fsk off", 200);
   endtask

   // fill the buffer until it refuses, then a second reset empties it
   task automatic t_fifo();
      repeat (5) u_uart.q.push_back(1'b1);
      repeat (20) @(posedge ref_clk);
      check("bit_ready", 32'h0, {31'h0, bit_ready});
      check("queued", 32'h1, 32'(u_uart.q.size()));
      rreg(ADDR_STATUS);
      check("nonempty", 32'h2, r & 32'h2);
      u_uart.q.delete();
      rst_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check("bit_ready", 32'h1, {31'h0, bit_ready});
      check("inv_en", 32'h0, {31'h0, inv_en});
   endtask

   // current bit holds mark until the first boundary, then the queued space follows
   task automatic t_fsk(input logic std, input logic rate, input int fs, input int fm);
      int tv;
      int n;
      n = 0;
      wreg(ADDR_SETUP, {std, 1'b1, 6'h00});
      u_uart.q.push_back(1'b0);
      wreg(ADDR_MODE, {6'h00, 1'b1, rate});
      // let the step out of mid level pass before measuring
      repeat (2) @(posedge ref_clk);
      tvar(6000, tv);
      near("mark", fm, 6000, tv);
      rreg(ADDR_STATUS);
      while (r[0] !== 1'b0 && n < 1000) begin
         n++;
         rreg(ADDR_STATUS);
      end
      check("bit boundary", 32'h0, {31'h0, r[0]});
      tvar(6000, tv);
      near("space", fs, 6000, tv);
      wreg(ADDR_MODE, 8'h00);
   endtask

   task automatic t_tones();
      int tv;
      int codes [4] = '{0, 7, 8, 13};
      int freqs [4] = '{1633, 1209, 852, 697};
      wreg(ADDR_TONES, 8'hD0);
      foreach (codes[i]) begin
         wreg(ADDR_CODE, 8'(codes[i]));
         tvar(3000, tv);
         near("single tone", freqs[i], 3000, tv);
      end
      wreg(ADDR_TONES, 8'hC0);
      dual(8'h00, 941, 1633);
      dual(8'h05, 770, 1336);
      wreg(ADDR_TONES, 8'h90);
      hold_mid("gate off", 100);
   endtask

   // ----------
   // main sequence
   // ----------
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_regs();
      t_disabled();
      t_fifo();
      t_fsk(1'b0, 1'b0, 450, 390);
      t_fsk(1'b0, 1'b1, 2100, 1300);
      t_fsk(1'b1, 1'b0, 487, 387);
      t_fsk(1'b1, 1'b1, 2200, 1200);
      t_tones();
      final_report();
   end

   // run needs about 72k cycles; a hang ends it here
   initial begin
      repeat (100000) @(posedge ref_clk);
      bad_count++;
      final_report();
   end
endmodule // testbench
`default_nettype wire
